//--- verilog/serial_prescale_pkg.sv
/*
  Constants shared by the prescaler / interrupt-condition block and its FIFO:
  register byte addresses, field positions, reset values, FIFO geometry.
  Assumes a 32-bit AXI4-Lite address space decoded on the full address.
*/
package serial_prescale_pkg;

  // Register byte addresses
  localparam logic [31:0] data_addr            = 32'h4004_0008;
  localparam logic [31:0] clock_prescale_addr  = 32'h4004_0010;
  localparam logic [31:0] interrupt_enable_addr = 32'h4004_0014;
  localparam logic [31:0] raw_status_addr      = 32'h4004_0018;
  localparam logic [31:0] masked_status_addr   = 32'h4004_001c;
  localparam logic [31:0] interrupt_clear_addr = 32'h4004_0020;

  // Interrupt bit positions
  localparam int overrun_bit  = 0;
  localparam int timeout_bit  = 1;
  localparam int rx_level_bit = 2;
  localparam int tx_level_bit = 3;
  localparam int irq_bits     = 4;

  // Reset values
  localparam logic [7:0] prescale_reset = 8'h00;
  localparam logic [3:0] enable_reset   = 4'h0;

  // Divisor range and time-out length in bit periods
  localparam logic [7:0] prescale_min  = 8'h02;
  localparam logic [5:0] timeout_bits  = 6'h20;

  // FIFO geometry
  localparam int frame_width = 16;
  localparam int fifo_depth  = 16;
  localparam int level_width = 5;
  localparam logic [4:0] half_depth = 5'h08;

  // AXI responses
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

endpackage

//--- verilog/frame_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and a fill level output.
  Read data comes from a register holding the head word.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module frame_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         in_valid,
  input  wire logic [WIDTH-1:0]             in_data,
  output logic                              in_ready,
  output logic                              out_valid,
  output logic      [WIDTH-1:0]             out_data,
  input  wire logic                         out_ready,
  output logic      [$clog2(DEPTH+1)-1:0]   level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic             push;
  logic             pop;

  // Handshakes
  assign in_ready    = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid   = (level != '0);
  assign push        = in_valid && in_ready;
  assign pop         = out_valid && out_ready;
  assign next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;

  // Storage
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      rd_ptr <= next_rd_ptr;
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end

  // Registered head word, bypassing a write into the next head slot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_data <= '0;
    end else if (push && (wr_ptr == next_rd_ptr)) begin
      out_data <= in_data;
    end else begin
      out_data <= mem[next_rd_ptr];
    end
  end

endmodule

`default_nettype wire

//--- verilog/serial_prescale_interrupts.sv
/*
  Bit-clock prescaler, receive/transmit FIFOs and interrupt conditions of a
  synchronous serial controller, reached over AXI4-Lite.
  Assumes the frame shifter outside supplies received frames, drains transmit
  frames, and provides mode, clock rate factor and the slave bit tick.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_prescale_interrupts
  import serial_prescale_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [31:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [31:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   master_mode,
  input  wire logic [7:0]             serial_clock_rate_factor,
  input  wire logic                   slave_bit_tick,
  output logic                        shift_tick,
  input  wire logic                   rx_frame_valid,
  input  wire logic [frame_width-1:0] rx_frame_data,
  output logic                        rx_frame_ready,
  output logic                        tx_frame_valid,
  output logic [frame_width-1:0]      tx_frame_data,
  input  wire logic                   tx_frame_ready,
  output logic                        irq
);

  logic [7:0]             prescale_divisor;
  logic [irq_bits-1:0]    interrupt_enable;
  logic [7:0]             prescale_count;
  logic [7:0]             rate_count;
  logic                   prescale_tick;
  logic                   bit_tick;
  logic [5:0]             timeout_count;
  logic                   overrun_raw_flag;
  logic                   timeout_raw_flag;
  logic [irq_bits-1:0]    raw_status;
  logic [irq_bits-1:0]    masked_status;
  logic [level_width-1:0] rx_level;
  logic [level_width-1:0] tx_level;
  logic                   rx_out_valid;
  logic [frame_width-1:0] rx_out_data;
  logic                   rx_pop;
  logic                   tx_in_ready;
  logic                   tx_push;
  logic                   aw_held;
  logic [31:0]            aw_addr;
  logic                   w_held;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   write_go;
  logic                   write_mapped;
  logic                   clear_overrun;
  logic                   clear_timeout;
  logic                   overrun_event;
  logic                   frame_taken;

  // Receive FIFO between frame shifter and software
  frame_fifo #(
    .WIDTH (frame_width),
    .DEPTH (fifo_depth)
  ) rx_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (rx_frame_valid),
    .in_data   (rx_frame_data),
    .in_ready  (rx_frame_ready),
    .out_valid (rx_out_valid),
    .out_data  (rx_out_data),
    .out_ready (rx_pop),
    .level     (rx_level)
  );

  // Transmit FIFO between software and frame shifter
  frame_fifo #(
    .WIDTH (frame_width),
    .DEPTH (fifo_depth)
  ) tx_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (tx_push),
    .in_data   (w_data[frame_width-1:0]),
    .in_ready  (tx_in_ready),
    .out_valid (tx_frame_valid),
    .out_data  (tx_frame_data),
    .out_ready (tx_frame_ready),
    .level     (tx_level)
  );

  // prescaler tick
  // Divisor below the minimum leaves the prescaler idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale_count <= '0;
    end else if (prescale_divisor < prescale_min || prescale_tick) begin
      prescale_count <= '0;
    end else begin
      prescale_count <= prescale_count + 8'h01;
    end
  end
  assign prescale_tick = (prescale_divisor >= prescale_min)
                      && (prescale_count >= prescale_divisor - 8'h01);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_count <= '0;
    end else if (prescale_tick) begin
      rate_count <= bit_tick ? 8'h00 : rate_count + 8'h01;
    end
  end
  // At-least compare so a lowered factor cannot strand the count for a full wrap
  assign bit_tick = prescale_tick && (rate_count >= serial_clock_rate_factor);

  // relies on the partner pacing slave_bit_tick
  assign shift_tick = master_mode ? bit_tick : slave_bit_tick;

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign tx_push       = aw_held && w_held && !s_axi_bvalid
                      && (aw_addr == data_addr) && (w_strb != 4'h0);
  assign write_go      = aw_held && w_held && !s_axi_bvalid
                      && ((aw_addr != data_addr) || tx_in_ready || (w_strb == 4'h0));
  assign write_mapped  = (aw_addr == data_addr) || (aw_addr == clock_prescale_addr)
                      || (aw_addr == interrupt_enable_addr)
                      || (aw_addr == interrupt_clear_addr);

  // Capture of address and data halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (write_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (write_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= resp_okay;
    end else if (write_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= write_mapped ? resp_okay : resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale_divisor <= prescale_reset;
      interrupt_enable <= enable_reset;
    end else if (write_go && w_strb[0]) begin
      if (aw_addr == clock_prescale_addr) begin
        prescale_divisor <= {w_data[7:1], 1'b0};
      end
      if (aw_addr == interrupt_enable_addr) begin
        interrupt_enable <= w_data[irq_bits-1:0];
      end
    end
  end

  assign clear_overrun = write_go && w_strb[0] && (aw_addr == interrupt_clear_addr)
                      && w_data[overrun_bit];
  assign clear_timeout = write_go && w_strb[0] && (aw_addr == interrupt_clear_addr)
                      && w_data[timeout_bit];

  assign overrun_event = rx_frame_valid && !rx_frame_ready;
  assign frame_taken   = rx_frame_valid && rx_frame_ready;

  // sticky overrun flag
  // Set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_raw_flag <= 1'b0;
    end else if (overrun_event) begin
      overrun_raw_flag <= 1'b1;
    end else if (clear_overrun) begin
      overrun_raw_flag <= 1'b0;
    end
  end

  // time-out counter restart
  // Counts bit periods of the internal rate in both modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_count <= '0;
    end else if (!rx_out_valid || rx_pop || frame_taken || overrun_event) begin
      timeout_count <= '0;
    end else if (bit_tick && timeout_count != timeout_bits) begin
      timeout_count <= timeout_count + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_raw_flag <= 1'b0;
    end else if (bit_tick && rx_out_valid && !rx_pop && !frame_taken && !overrun_event
                 && timeout_count == timeout_bits - 6'h01) begin
      timeout_raw_flag <= 1'b1;
    end else if (clear_timeout) begin
      timeout_raw_flag <= 1'b0;
    end
  end

  always_comb begin
    raw_status               = '0;
    raw_status[overrun_bit]  = overrun_raw_flag;
    raw_status[timeout_bit]  = timeout_raw_flag;
    raw_status[rx_level_bit] = (rx_level >= half_depth);
    raw_status[tx_level_bit] = (tx_level <= half_depth);
  end

  assign masked_status = raw_status & interrupt_enable;
  assign irq = |masked_status;

  // Read channel, one read at a time; data register read pops receive FIFO
  assign s_axi_arready = !s_axi_rvalid;
  assign rx_pop        = s_axi_arvalid && !s_axi_rvalid && (s_axi_araddr == data_addr);

  // Read data and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= resp_okay;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= resp_okay;
      case (s_axi_araddr)
        data_addr:             s_axi_rdata <= {16'h0000, rx_out_valid ? rx_out_data : 16'h0000};
        clock_prescale_addr:   s_axi_rdata <= {24'h000000, prescale_divisor};
        interrupt_enable_addr: s_axi_rdata <= {28'h0000000, interrupt_enable};
        raw_status_addr:       s_axi_rdata <= {28'h0000000, raw_status};
        masked_status_addr:    s_axi_rdata <= {28'h0000000, masked_status};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= resp_slverr;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- sim/serial_prescale_checker.sv
/*
  Port checker for the prescaler and interrupt block.
  Assumes it is bound to serial_prescale_interrupts and shares its clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_prescale_checker
  import serial_prescale_pkg::*;
(
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic [31:0]            s_axi_awaddr,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire logic                   master_mode,
  input wire logic                   slave_bit_tick,
  input wire logic                   shift_tick,
  input wire logic                   rx_frame_ready,
  input wire logic                   tx_frame_valid,
  input wire logic [frame_width-1:0] tx_frame_data,
  input wire logic                   tx_frame_ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Control write taken in one edge, then its answer
  sequence ctrl_write;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr != data_addr;
  endsequence
  sequence answer_soon;
    ##[1:3] s_axi_bvalid;
  endsequence
  write_answer_a: assert property (ctrl_write |-> answer_soon)
    else $error("write answer late");
  ready_again_a: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
    else $error("write channels not free after answer");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_free_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  slave_tick_a: assert property (!master_mode |-> shift_tick == slave_bit_tick)
    else $error("slave bit tick not followed");
  master_tick_a: assert property (master_mode && shift_tick |=> !shift_tick || !master_mode)
    else $error("master bit tick too fast");
  tx_hold_a: assert property (tx_frame_valid && !tx_frame_ready |=> tx_frame_valid && $stable(tx_frame_data))
    else $error("transmit frame not held");
  rx_full_a: assert property (!rx_frame_ready && !s_axi_arvalid && !s_axi_rvalid |=> !rx_frame_ready)
    else $error("full receive buffer emptied without a read");
endmodule
bind serial_prescale_interrupts serial_prescale_checker chk (.*);
`default_nettype wire

//--- sim/frame_partner.sv
/*
  Model of the frame shifter side: hands in received frames, drains
  transmit frames slowly or not at all, and makes an external bit tick.
  Assumes the block's clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module frame_partner (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        tick_on,
  input  wire logic        stall,
  output logic             rx_frame_valid,
  output logic [15:0]      rx_frame_data,
  output logic             tx_frame_ready,
  output logic             slave_bit_tick
);
  logic [3:0] tick_count;
  initial begin
    rx_frame_valid = 1'b0;
    rx_frame_data = 16'h5a5a;
  end
  // A finished frame is offered for one cycle; the line then shows junk
  task automatic send(input logic [15:0] v);
    @(posedge aclk);
    rx_frame_valid <= 1'b1;
    rx_frame_data  <= v;
    @(posedge aclk);
    rx_frame_valid <= 1'b0;
    rx_frame_data  <= ~v;
  endtask
  // Takes a transmit frame every other cycle unless stalled
  always_ff @(posedge aclk) begin
    if (!aresetn) tx_frame_ready <= 1'b0;
    else tx_frame_ready <= !stall && !tx_frame_ready;
  end
  // slow external clock
  // One bit tick in twelve cycles, still while off
  always_ff @(posedge aclk) begin
    if (!aresetn || !tick_on) tick_count <= 4'h0;
    else tick_count <= (tick_count == 4'hb) ? 4'h0 : tick_count + 4'h1;
  end
  assign slave_bit_tick = tick_on && (tick_count == 4'hb);
endmodule
`default_nettype wire

//--- sim/tb.sv
/*
  Self-checking bench for the prescaler and interrupt block.
  Assumes frame_partner on the frame side and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import serial_prescale_pkg::*;
;
  logic        aclk, aresetn = 1'b0, irq;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, seed = 32'h2, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, stall = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, master_mode = 1'b1, tick_on = 1'b0;
  logic [7:0]  serial_clock_rate_factor = 8'h00;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        shift_tick, rx_frame_valid, rx_frame_ready, tx_frame_valid, tx_frame_ready;
  logic        slave_bit_tick;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rresp_q[$], bresp_q[$];
  logic [15:0] rx_frame_data, tx_frame_data, rx_q[$];
  logic [31:0] exp_q[$], mask_q[$], tx_q[$];
  logic [7:0]  dv[4] = '{8'h02, 8'h04, 8'h07, 8'hff}, fc[4] = '{8'h00, 8'h02, 8'h01, 8'h00};
  int          miscompares = 0, samples_checked = 0;
  serial_prescale_interrupts uut (.*);
  frame_partner partner (.*);
  // Clock, 100 ns period
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Pseudo-random words
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check_read();
    logic [31:0] e, m;
    logic [1:0] r;
    e = exp_q.pop_front();
    m = mask_q.pop_front();
    r = rresp_q.pop_front();
    samples_checked++;
    if (((s_axi_rdata ^ e) & m) !== 32'h0 || s_axi_rresp !== r) begin
      miscompares++;
      $display("MISMATCH %0t read %h exp %h", $time, s_axi_rdata, e);
    end
  endtask
  task automatic check_resp(input logic [1:0] r);
    samples_checked++;
    if (s_axi_bresp !== r) begin
      miscompares++;
      $display("MISMATCH %0t write answer %h exp %h", $time, s_axi_bresp, r);
    end
  endtask
  task automatic check_num(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t value %h exp %h", $time, g, e);
    end
  endtask
  // Watches answers and transmit frames, oldest note first
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) check_read();
    if (s_axi_bvalid === 1'b1 && s_axi_bready) check_resp(bresp_q.pop_front());
    if (tx_frame_valid === 1'b1 && tx_frame_ready) check_num(32'(tx_frame_data), tx_q.pop_front());
  end
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r);
    bresp_q.push_back(r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    fork
      begin do @(posedge aclk); while (s_axi_awready !== 1'b1); s_axi_awvalid <= 1'b0; end
      begin do @(posedge aclk); while (s_axi_wready !== 1'b1); s_axi_wvalid <= 1'b0; end
    join
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, e, m, input logic [1:0] r);
    exp_q.push_back(e);
    mask_q.push_back(m);
    rresp_q.push_back(r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  // Cycles between two bit ticks, after settling on two ticks
  task automatic period(input int e);
    int n;
    n = 0;
    repeat (2) do @(posedge aclk); while (shift_tick !== 1'b1);
    do begin @(posedge aclk); n++; end while (shift_tick !== 1'b1);
    check_num(32'(n), 32'(e));
  endtask
  task automatic finish_test();
    $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(clock_prescale_addr, 32'h0, 32'hff, resp_okay);
    rd(interrupt_enable_addr, 32'h0, 32'hf, resp_okay);
    rd(raw_status_addr, 32'h8, 32'hf, resp_okay);
    rd(masked_status_addr, 32'h0, 32'hf, resp_okay);
    // Receive buffer to half, to full, then one frame too many
    for (int i = 0; i < 17; i++) begin
      d = rnd();
      if (i < 16) rx_q.push_back(d[15:0]);
      partner.send(d[15:0]);
      if (i == 6) rd(raw_status_addr, 32'h8, 32'hf, resp_okay);
      if (i == 7) rd(raw_status_addr, 32'hc, 32'hf, resp_okay);
    end
    rd(raw_status_addr, 32'hd, 32'hf, resp_okay);
    wr(interrupt_enable_addr, 32'hffff_fff5, resp_okay);
    rd(masked_status_addr, 32'h5, 32'hf, resp_okay);
    check_num(32'(irq), 32'h1);
    wr(interrupt_clear_addr, 32'h1, resp_okay);
    rd(raw_status_addr, 32'hc, 32'hf, resp_okay);
    while (rx_q.size() > 0) rd(data_addr, 32'(rx_q.pop_front()), 32'hffff, resp_okay);
    check_num(32'(irq), 32'h0);
    // Unread frame with a two-cycle bit period
    wr(clock_prescale_addr, 32'h2, resp_okay);
    d = rnd();
    partner.send(d[15:0]);
    repeat (40) @(posedge aclk);
    rd(raw_status_addr, 32'h8, 32'hf, resp_okay);
    repeat (40) @(posedge aclk);
    rd(raw_status_addr, 32'ha, 32'hf, resp_okay);
    rd(data_addr, 32'(d[15:0]), 32'hffff, resp_okay);
    wr(interrupt_clear_addr, 32'h2, resp_okay);
    repeat (100) @(posedge aclk);
    rd(raw_status_addr, 32'h8, 32'hf, resp_okay);
    // Divisor and rate factor table
    for (int i = 0; i < 4; i++) begin
      d = {24'h0, dv[i]};
      wr(clock_prescale_addr, d, resp_okay);
      rd(clock_prescale_addr, d & 32'hfe, 32'hff, resp_okay);
      serial_clock_rate_factor <= fc[i];
      period(int'(d & 32'hfe) * (int'(fc[i]) + 1));
    end
    master_mode <= 1'b0;
    tick_on <= 1'b1;
    period(12);
    master_mode <= 1'b1;
    // Transmit buffer filled while the far side stalls
    stall <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      d = rnd();
      tx_q.push_back(32'(d[15:0]));
      wr(data_addr, d, resp_okay);
      if (i == 7) rd(raw_status_addr, 32'h8, 32'h8, resp_okay);
      if (i == 8) rd(raw_status_addr, 32'h0, 32'h8, resp_okay);
    end
    d = rnd();
    tx_q.push_back(32'(d[15:0]));
    fork
      wr(data_addr, d, resp_okay);
      begin repeat (30) @(posedge aclk); stall <= 1'b0; end
    join
    repeat (80) @(posedge aclk);
    rd(raw_status_addr, 32'h8, 32'h8, resp_okay);
    wr(32'h4004_0030, rnd(), resp_slverr);
    rd(32'h4004_0030, 32'h0, 32'hffff_ffff, resp_slverr);
    wr(raw_status_addr, 32'hf, resp_slverr);
    // Low byte strobe off: the divisor must keep its value
    s_axi_wstrb <= 4'he;
    wr(clock_prescale_addr, 32'h10, resp_okay);
    s_axi_wstrb <= 4'hf;
    rd(clock_prescale_addr, 32'hfe, 32'hff, resp_okay);
    rd(raw_status_addr, 32'h8, 32'hf, resp_okay);
    repeat (5) @(posedge aclk);
    finish_test();
  end
endmodule
`default_nettype wire
